// ===== buffer_store.sv
/*
 * Storage for the byte-count block: the 68-byte data buffer memory with a
 * registered read port, and the small transmit stream FIFO.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

// data buffer memory, one write and one registered read port
module buffer_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 68,
	parameter int AW    = 7
) (
	input  wire logic             clk,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// contents are not reset, matching a real buffer array
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// synchronous fifo, valid/ready on both sides
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	wire              push        = in_valid && in_ready;
	wire              pop         = out_valid && out_ready;
	wire  [AW-1:0]    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
	wire  [AW:0]      next_fill   = (AW+1)'(fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
	// a push into an emptying fifo is the next head word at once
	wire              head_is_new = push && (next_rd_ptr == wr_ptr);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// flags and head word registered, so stream outputs leave flip-flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			fill      <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			if (push) wr_ptr <= bump(wr_ptr);
			rd_ptr    <= next_rd_ptr;
			fill      <= next_fill;
			in_ready  <= (next_fill != (AW+1)'(DEPTH));
			out_valid <= (next_fill != '0);
			out_data  <= head_is_new ? in_data : mem[next_rd_ptr];
		end
	end
endmodule

`default_nettype wire

// ===== buffered_byte_count_pointer_tb.sv
/* self-checking bench for the byte count and buffer pointer block.
 * Assumes the map header and package compiled ahead of it. */
`timescale 1ns/1ps
`default_nettype none
`include "byte_count_map.svh"

module buffered_byte_count_pointer_tb;
	import byte_count_pkg::*;
	localparam logic [1:0] A_DAT = `ADDR_DATA_PORT;
	localparam logic [1:0] A_CNT = `ADDR_COUNT;
	localparam logic [1:0] A_CTL = `ADDR_CONTROL;
	// event codes {byte_done, is_addr, acked, hit, done, rx}
	localparam logic [5:0] E_AK = 6'h38, E_NK = 6'h30, E_BD = 6'h20;
	localparam logic [5:0] E_HIT = 6'h04, E_DN = 6'h02;
	logic       clk = '0, nrst = '0, wr = '0, rd = '0, istx = '0, bd = '0;
	logic       isad = '0, ack = '0, hit = '0, done = '0, rxv = '0;
	logic       stall = '0, slow = '0, rdy, lb, txv, sst;
	logic [1:0] adr = '0;
	logic [7:0] wd = '0, dst = '0, rxb = '0, rdat, txd, ctl, sta, q;
	logic [6:0] cnt;
	int         n_fail = 0, cmp_count = 0, cyc = 0;

	byte_count_pointer i_dut (.clk(clk), .nrst(nrst), .host_addr(adr), .host_wr(wr),
		.host_rd(rd), .host_wdata(wd), .host_rdata(rdat), .is_transmitter(istx),
		.byte_done(bd), .byte_is_addr(isad), .addr_acked(ack), .slave_addr_hit(hit),
		.seq_done(done), .done_status(dst), .rx_byte_valid(rxv), .rx_byte(rxb),
		.tx_data(txd), .tx_valid(txv), .tx_ready(rdy), .seq_start(sst),
		.count_field(cnt), .last_byte_refuse(lb), .control_register(ctl),
		.status_register(sta));
	sink_model i_sink (.clk(clk), .stall(stall), .slow(slow), .tx_data(txd),
		.tx_valid(txv), .tx_ready(rdy));

	always #10 clk = ~clk;
	// hang guard, far above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic conclude();
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch at %0t: got %h want %h", $time, g, e);
			n_fail++;
		end
	endtask

	// one-cycle write strobe, raised and dropped at falling edges
	task automatic hw(input logic [1:0] a, input logic [7:0] d);
		@(negedge clk);
		adr = a;
		wd = d;
		wr = 1'h1;
		@(negedge clk);
		wr = 1'h0;
	endtask

	// read lands in q; the spare cycle keeps data reads apart
	task automatic hr(input logic [1:0] a);
		@(negedge clk);
		adr = a;
		rd = 1'h1;
		@(negedge clk);
		rd = 1'h0;
		q = rdat;
		@(negedge clk);
	endtask

	task automatic ev(input logic [5:0] k, input logic [7:0] b);
		@(negedge clk);
		{bd, isad, ack, hit, done, rxv} = k;
		rxb = b;
		dst = b;
		@(negedge clk);
		{bd, hit, done, rxv} = 4'h0;
	endtask

	task automatic go();
		hw(A_CTL, 8'h01);
		chk(sst, 8'h01);
	endtask

	task automatic cnt_is(input logic [7:0] e);
		hr(A_CNT);
		chk(q, e);
	endtask

	task automatic s_reset();
		chk(sta, 8'hf8);
		chk(ctl, 8'h00);
		chk(txv, 8'h00);
		chk(sst, 8'h00);
		cnt_is(8'h00);
	endtask

	// 12 bytes against a stalled sink: fifo fills, then drains slowly
	task automatic s_tx();
		istx = 1'h1;
		stall = 1'h1;
		hw(A_CNT, 8'h0c);
		for (int i = 0; i < 12; i++)
			hw(A_DAT, 8'(8'h30 + i));
		go();
		repeat (30) @(negedge clk);
		chk(txv, 8'h01);
		chk(8'(i_sink.got.size()), 8'h00);
		slow = 1'h1;
		stall = 1'h0;
		for (int k = 0; k < 300 && i_sink.got.size() < 12; k++)
			@(negedge clk);
		repeat (10) @(negedge clk);
		chk(8'(i_sink.got.size()), 8'h0c);
		chk(txv, 8'h00);
		for (int i = 0; i < 12; i++)
			chk(i_sink.got[i], 8'(8'h30 + i));
		slow = 1'h0;
		ev(E_AK, 8'h00);
		for (int i = 0; i < 11; i++)
			ev(E_BD, 8'h00);
		ev(E_DN, 8'h28);
		cnt_is(8'h0c);
		chk(sta, 8'h28);
	endtask

	// launch, issue up to three events, complete, then read the count
	task automatic run(input logic t, input logic [7:0] c, input logic [5:0] e0,
		input logic [5:0] e1, input logic [5:0] e2, input int n, input logic [7:0] x);
		logic [5:0] e[3];
		e = '{e0, e1, e2};
		istx = t;
		hw(A_CNT, c);
		go();
		for (int i = 0; i < n; i++)
			ev(e[i], 8'h00);
		ev(E_DN, 8'h10);
		cnt_is(x);
	endtask

	task automatic s_runs();
		run(1'h1, 8'h01, E_AK, 6'h0, 6'h0, 1, 8'h01);
		run(1'h1, 8'h01, E_NK, 6'h0, 6'h0, 1, 8'h01);
		run(1'h1, 8'h01, 6'h0, 6'h0, 6'h0, 0, 8'h00);
		run(1'h1, 8'h01, E_HIT, 6'h0, 6'h0, 1, 8'h00);
		run(1'h1, 8'h03, E_AK, E_BD, E_BD, 3, 8'h03);
		run(1'h1, 8'h03, E_BD, E_BD, 6'h0, 2, 8'h02);
		run(1'h0, 8'h03, E_NK, 6'h0, 6'h0, 1, 8'h01);
		run(1'h0, 8'h03, 6'h0, 6'h0, 6'h0, 0, 8'h00);
		run(1'h0, 8'h03, E_HIT, 6'h0, 6'h0, 1, 8'h00);
		run(1'h1, 8'h02, E_HIT, E_BD, E_BD, 3, 8'h02);
	endtask

	task automatic s_rx();
		istx = 1'h0;
		hw(A_CNT, 8'h03);
		go();
		ev(E_AK, 8'h00);
		for (int i = 0; i < 3; i++)
			ev(6'h21, 8'(8'hc0 + i));
		ev(E_DN, 8'h50);
		cnt_is(8'h03);
		chk(sta, 8'h50);
		for (int i = 0; i < 3; i++) begin
			hr(A_DAT);
			chk(q, 8'(8'hc0 + i));
		end
	endtask

	// boundary 44h launches; 00h and 45h are refused
	task automatic s_invalid();
		for (int i = 0; i < 2; i++) begin
			hw(A_CTL, 8'h00);
			hw(A_CNT, 8'h44);
			go();
			ev(E_DN, 8'h50);
			hw(A_CNT, i ? 8'h45 : 8'h00);
			hw(A_CTL, 8'h01);
			chk(sst, 8'h00);
			chk(sta, 8'hfc);
			chk(ctl[3], 8'h01);
			hw(A_CTL, 8'h11);
			chk(sst, 8'h00);
			chk(ctl[3], 8'h00);
		end
	endtask

	task automatic s_lb();
		hw(A_CNT, 8'hc0);
		cnt_is(8'hc0);
		chk(lb, 8'h01);
		chk(cnt, 8'h40);
	endtask

	// 69 writes: the last one lands on location zero
	task automatic s_wrap();
		hw(A_CNT, 8'h01);
		for (int i = 0; i < 69; i++)
			hw(A_DAT, 8'(i));
		hw(A_CNT, 8'h01);
		repeat (2) @(negedge clk);
		hr(A_DAT);
		chk(q, 8'h44);
		hr(A_DAT);
		chk(q, 8'h01);
	endtask

	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'h1;
		s_reset();
		s_tx();
		s_runs();
		s_rx();
		s_invalid();
		s_lb();
		s_wrap();
		conclude();
	end
endmodule

`default_nettype wire

// ===== byte_count_map.svh
/*
 * Constant map of the buffered byte-count and buffer-pointer block:
 * register addresses, control field positions, limits and status codes.
 * Assumes it is included by its bare name, ahead of any module that uses it.
 */
`ifndef BYTE_COUNT_MAP_SVH
`define BYTE_COUNT_MAP_SVH

// host register addresses
`define ADDR_STATUS     2'h0
`define ADDR_DATA_PORT  2'h1
`define ADDR_COUNT      2'h2
`define ADDR_CONTROL    2'h3

// control register field positions
`define CTL_MODE_BIT    0
`define CTL_SI_BIT      3
`define CTL_STOP_BIT    4
`define CTL_START_BIT   5

// byte count register layout
`define CNT_LB_BIT      7
`define CNT_FIELD_MSB   6

// buffer limits and pointer values
`define BUF_BYTES       68
`define CNT_MAX         7'h44
`define PTR_LAST        7'h43
`define PTR_FIRST       7'h00
`define CNT_ZERO        7'h00
`define CNT_ONE         7'h01

// status codes and reset values
`define STATUS_INVALID  8'hfc
`define STATUS_RESET    8'hf8
`define CONTROL_RESET   8'h00
`define COUNT_RESET     8'h00

// tx stream buffering
`define TX_FIFO_DEPTH   8

`endif

// ===== byte_count_pkg.sv
/*
 * Types shared by the buffered byte-count block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package byte_count_pkg;

	// transmit feeder sequencer, one-hot
	typedef enum logic [2:0] {
		FEED_IDLE = 3'b001,
		FEED_READ = 3'b010,
		FEED_PUSH = 3'b100
	} feed_state_type;

endpackage

// ===== byte_count_pointer.sv
/*
 * Byte count register, data buffer pointer and transmit feeder of a
 * buffered two-wire bus controller. Host side is a simple strobed
 * register port; serial side is a sequencer that reports byte and
 * sequence events and drains the transmit stream.
 * Assumes host strobes and sequencer events are synchronous one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "byte_count_map.svh"

// Overview of operation
// - writing the count register returns the buffer pointer to the first byte.
// - on completion the count register shows bytes sent or received.
// - buffered transmit starts with the first byte the host loaded if the feeder is idle and the tx fifo empty at launch.
// - receiver completion returns the pointer to the first received byte.
// - master transmitter address phase alone reports a count of one.
// - master transmitter address plus n data bytes reports n plus one.
// - arbitration lost in a write address reports zero.
// - arbitration lost in data byte n reports completed bytes only.
// - master receiver counts n data bytes; a refused address counts one.
// - arbitration lost in read address gives zero, in nth acknowledge n.
// - slave receiver reports zero after its write address is acknowledged.
// - slave transmitter reports zero after address, then n bytes sent.
// - zero or over 68 count: no transfer, interrupt flag, invalid status code.
// - top count bit asks to refuse the last received byte.
// - no overrun guard; the pointer wraps past 68 to location zero.
module byte_count_pointer
	import byte_count_pkg::*;
#(
	parameter int BUF_DEPTH  = `BUF_BYTES,
	parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [1:0] host_addr,
	input  wire logic       host_wr,
	input  wire logic       host_rd,
	input  wire logic [7:0] host_wdata,
	output logic      [7:0] host_rdata,
	input  wire logic       is_transmitter,
	input  wire logic       byte_done,
	input  wire logic       byte_is_addr,
	input  wire logic       addr_acked,
	input  wire logic       slave_addr_hit,
	input  wire logic       seq_done,
	input  wire logic [7:0] done_status,
	input  wire logic       rx_byte_valid,
	input  wire logic [7:0] rx_byte,
	output logic      [7:0] tx_data,
	output logic            tx_valid,
	input  wire logic       tx_ready,
	output logic            seq_start,
	output logic      [6:0] count_field,
	output logic            last_byte_refuse,
	output logic      [7:0] control_register,
	output logic      [7:0] status_register
);
	feed_state_type state;
	logic [6:0]     ptr;
	logic [6:0]     seq_count;
	logic [6:0]     feed_ptr;
	logic [6:0]     feed_left;
	logic [7:0]     mem_q;

	// one wrap point for every buffer pointer
	function automatic logic [6:0] ptr_next(input logic [6:0] p);
		ptr_next = (p == `PTR_LAST) ? `PTR_FIRST : 7'(p + `CNT_ONE);
	endfunction

	function automatic logic count_ok(input logic [6:0] c);
		count_ok = (c != `CNT_ZERO) && (c <= `CNT_MAX);
	endfunction

	// host access decode
	wire wr_count = host_wr && (host_addr == `ADDR_COUNT);
	wire wr_ctl   = host_wr && (host_addr == `ADDR_CONTROL);
	wire wr_data  = host_wr && (host_addr == `ADDR_DATA_PORT);
	wire rd_data  = host_rd && (host_addr == `ADDR_DATA_PORT);
	wire data_acc = wr_data || rd_data;

	// a launch write asks for a sequence; a stop-only write is never checked
	wire launch   = wr_ctl && host_wdata[`CTL_MODE_BIT] && !host_wdata[`CTL_SI_BIT]
	                && !host_wdata[`CTL_STOP_BIT];
	wire invalid  = launch && !count_ok(count_field);
	wire start_ok = launch && count_ok(count_field);

	// a refused read address is counted, an acknowledged one is not
	wire skip_byte  = byte_is_addr && addr_acked && !is_transmitter;
	wire count_step = byte_done && !skip_byte;
	wire [6:0] next_seq_count = slave_addr_hit ? `CNT_ZERO :
	                            start_ok       ? `CNT_ZERO :
	                            count_step     ? 7'(seq_count + `CNT_ONE) : seq_count;

	// si is set by completion or invalid count, cleared by writing zero
	wire si_set   = seq_done || invalid;
	wire si_clear = wr_ctl && !host_wdata[`CTL_SI_BIT];
	wire next_si  = si_set || (control_register[`CTL_SI_BIT] && !si_clear);

	// buffer ports: rx bytes win the write port over host data writes
	wire       mem_we    = rx_byte_valid || wr_data;
	wire [7:0] mem_wdata = rx_byte_valid ? rx_byte : host_wdata;
	wire [6:0] mem_raddr = (state == FEED_READ) ? feed_ptr : ptr;

	// feeder handshake into the tx fifo
	wire       fifo_in_ready;
	wire       fifo_push = (state == FEED_PUSH);

	// host pointer: count write and rx completion send it home
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ptr <= `PTR_FIRST;
		end else if (wr_count) begin
			ptr <= `PTR_FIRST;
		end else if (seq_done && !is_transmitter) begin
			ptr <= `PTR_FIRST;
		end else if (data_acc || rx_byte_valid) begin
			ptr <= ptr_next(ptr);
		end
	end

	// bytes completed in the running sequence
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seq_count <= `CNT_ZERO;
		end else begin
			seq_count <= next_seq_count;
		end
	end

	// count register: host value, then the result of each sequence
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_field      <= `CNT_ZERO;
			last_byte_refuse <= 1'b0;
		end else if (wr_count) begin
			count_field      <= host_wdata[`CNT_FIELD_MSB:0];
			last_byte_refuse <= host_wdata[`CNT_LB_BIT];
		end else if (seq_done) begin
			count_field <= next_seq_count;
		end
	end

	// control and status registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			control_register <= `CONTROL_RESET;
			status_register  <= `STATUS_RESET;
			seq_start        <= 1'b0;
		end else begin
			if (wr_ctl) begin
				control_register <= host_wdata;
			end
			control_register[`CTL_SI_BIT] <= next_si;
			if (invalid) begin
				status_register <= `STATUS_INVALID;
			end else if (seq_done) begin
				status_register <= done_status;
			end
			seq_start <= start_ok;
		end
	end

	// host read data, registered; data port reads the prefetched byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_rdata <= 8'h00;
		end else if (host_rd) begin
			unique case (host_addr)
				`ADDR_STATUS:    host_rdata <= status_register;
				`ADDR_DATA_PORT: host_rdata <= mem_q;
				`ADDR_COUNT:     host_rdata <= {last_byte_refuse, count_field};
				`ADDR_CONTROL:   host_rdata <= control_register;
			endcase
		end
	end

	// feeder walks the buffer from location zero into the tx fifo
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state     <= FEED_IDLE;
			feed_ptr  <= `PTR_FIRST;
			feed_left <= `CNT_ZERO;
		end else begin
			unique case (state)
				FEED_IDLE: begin
					if (start_ok && is_transmitter) begin
						feed_ptr  <= `PTR_FIRST;
						feed_left <= count_field;
						state     <= FEED_READ;
					end
				end
				FEED_READ: begin
					if (feed_left == `CNT_ZERO) begin
						state <= FEED_IDLE;
					end else if (fifo_in_ready) begin
						state <= FEED_PUSH;
					end
				end
				FEED_PUSH: begin
					feed_ptr  <= ptr_next(feed_ptr);
					feed_left <= 7'(feed_left - `CNT_ONE);
					state     <= FEED_READ;
				end
				default: state <= FEED_IDLE;
			endcase
		end
	end

	buffer_ram #(
		.WIDTH (8),
		.DEPTH (BUF_DEPTH),
		.AW    (7)
	) u_buffer (
		.clk     (clk),
		.wr_en   (mem_we),
		.wr_addr (ptr),
		.wr_data (mem_wdata),
		.rd_addr (mem_raddr),
		.rd_data (mem_q)
	);

	// fifo lets the serial side stall; a full fifo holds the feeder in read
	stream_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (mem_q),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	a_count_wr_ptr: assert property (@(posedge clk) disable iff (!nrst)
		wr_count |=> (ptr == `PTR_FIRST)
		&& (count_field == $past(host_wdata[`CNT_FIELD_MSB:0])))
		else $error("pointer not home after count write");

	a_done_count: assert property (@(posedge clk) disable iff (!nrst)
		(seq_done && !wr_count) |=> count_field == $past(next_seq_count)
		&& control_register[`CTL_SI_BIT])
		else $error("count not loaded at completion");

	a_first_tx_byte: assert property (@(posedge clk) disable iff (!nrst)
		(start_ok && is_transmitter && state == FEED_IDLE)
		|=> (state == FEED_READ) && (feed_ptr == `PTR_FIRST)
		&& (mem_raddr == `PTR_FIRST))
		else $error("transmit does not start at first byte");

	a_rx_ptr_home: assert property (@(posedge clk) disable iff (!nrst)
		(seq_done && !is_transmitter) |=> ptr == `PTR_FIRST)
		else $error("rx pointer not returned to first byte");

	a_count_step: assert property (@(posedge clk) disable iff (!nrst)
		(byte_done && !skip_byte && !slave_addr_hit && !start_ok)
		|=> seq_count == 7'($past(seq_count) + `CNT_ONE))
		else $error("completed byte not counted");

	a_rx_addr_skip: assert property (@(posedge clk) disable iff (!nrst)
		(byte_done && skip_byte && !slave_addr_hit && !start_ok) |=> $stable(seq_count))
		else $error("acknowledged read address was counted");

	a_slave_zero: assert property (@(posedge clk) disable iff (!nrst)
		slave_addr_hit |=> seq_count == `CNT_ZERO)
		else $error("slave address did not report zero");

	a_invalid_code: assert property (@(posedge clk) disable iff (!nrst)
		invalid |=> (status_register == `STATUS_INVALID) && !seq_start
		&& control_register[`CTL_SI_BIT] ##1 (state == FEED_IDLE))
		else $error("invalid count not rejected");

	a_lb_kept: assert property (@(posedge clk) disable iff (!nrst)
		(seq_done && !wr_count) |=> $stable(last_byte_refuse))
		else $error("last byte refuse bit lost at completion");

	a_ptr_wrap: assert property (@(posedge clk) disable iff (!nrst)
		((data_acc || rx_byte_valid) && ptr == `PTR_LAST && !wr_count && !seq_done)
		|=> ptr == `PTR_FIRST)
		else $error("pointer did not wrap to zero");

	a_data_step: assert property (@(posedge clk) disable iff (!nrst)
		(data_acc && !wr_count && !seq_done) |=> ptr == ptr_next($past(ptr)))
		else $error("data access did not advance pointer");

	a_feed_exact: assert property (@(posedge clk) disable iff (!nrst)
		(state == FEED_PUSH) |-> fifo_in_ready && (feed_left != `CNT_ZERO))
		else $error("feeder pushed without room or budget");

	a_launch_pulse: assert property (@(posedge clk) disable iff (!nrst)
		start_ok |=> seq_start)
		else $error("accepted launch gave no start pulse");

endmodule

`default_nettype wire

// ===== sink_model.sv
/* tx stream sink standing in for the serial sequencer.
 * Assumes one clock; stall and slow are set by the bench. */
`timescale 1ns/1ps
`default_nettype none

module sink_model (
	input  wire logic       clk,
	input  wire logic       stall,
	input  wire logic       slow,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic       phase = 1'h0;
	logic [7:0] got[$];

	// slow mode takes a byte every other cycle only
	assign tx_ready = !stall && (!slow || phase);

	// keep bytes in the order they leave
	always @(posedge clk) begin
		phase <= !phase;
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule

`default_nettype wire
